// File: src/pse_top.sv
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
module pse_top #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // transaction context per bus side
  input wire pse_pkg::pse_side_s I_PRI_CTX,
  input wire pse_pkg::pse_side_s I_SEC_CTX,
  // delayed write completion phases on target bus
  input wire logic I_DS_DWR_CPL,
  input wire logic I_US_DWR_CPL,
  // posted write data phases on target bus
  input wire logic I_DS_PWR,
  input wire logic I_US_PWR,
  input wire logic I_PWR_TGT_DET,
  // queue events
  input wire logic I_PWR_TABORT,
  input wire logic I_PWR_MABORT,
  input wire logic I_PWR_RETRY_EXP,
  input wire logic I_DWR_RETRY_EXP,
  input wire logic I_DRD_RETRY_EXP,
  input wire logic I_MTIMEOUT,
  // bus error pins, inputs
  input wire logic I_PRI_PARITY_ERR_N,
  input wire logic I_SEC_PARITY_ERR_N,
  input wire logic I_SEC_SYSTEM_ERR_N,
  // bus error pins, outputs
  output logic O_PRI_PARITY_ERR_N,
  output logic O_PRI_PARITY_ERR_OE,
  output logic O_SEC_PARITY_ERR_N,
  output logic O_SEC_PARITY_ERR_OE,
  output logic O_PRI_SYSTEM_ERR_N,
  output logic O_PRI_SYSTEM_ERR_OE
);

  // offsets up to 0x10 need five address bits
  if (ADDR_W < 5 || ADDR_W > 32)
  begin : g_bad_addr_w
    $error("pse_top: ADDR_W must be 5..32");
  end

  pse_pkg::pse_cmd_s cmd_r;
  pse_pkg::pse_bctl_s bctl_r;
  logic [1:0] stat_r;
  logic [pse_pkg::EV_W-1:0] cause_r;
  logic [pse_pkg::EV_W-1:0] dis_r;
  logic [31:0] rdata_r;
  logic err_r;
  // turnaround state of one parity pin
  typedef struct packed {
    logic asrt;
    logic hold;
  } pse_pin_pair_s;

  pse_pin_pair_s pri_perr_r;
  pse_pin_pair_s sec_perr_r;
  logic pri_serr_r;

  function automatic logic [pse_pkg::EV_W-1:0] ev_gate(
    input logic [pse_pkg::EV_W-1:0] ev,
    input logic [pse_pkg::EV_W-1:0] dis,
    input pse_pkg::pse_bctl_s bc
  );
    logic [pse_pkg::EV_W-1:0] g;
    g = ev & ~(dis & pse_pkg::DIS_MASKABLE);
    g[pse_pkg::EV_MTIMEOUT] = ev[pse_pkg::EV_MTIMEOUT] & bc.mto_en;
    g[pse_pkg::EV_SEC_SERR] = ev[pse_pkg::EV_SEC_SERR] & bc.fwd_en;
    return g;
  endfunction : ev_gate

  function automatic logic addr_hit(
    input logic [ADDR_W-1:0] a,
    input logic [7:0] off
  );
    return a == ADDR_W'(off);
  endfunction : addr_hit

  // apb decode
  logic setup;
  logic wr_acc;
  logic sel_cmd;
  logic sel_bctl;
  logic sel_stat;
  logic sel_cause;
  logic sel_dis;
  logic mapped;

  assign setup = I_PSEL & ~I_PENABLE;
  assign wr_acc = I_PSEL & I_PENABLE & I_PWRITE;
  assign sel_cmd = addr_hit(I_PADDR, pse_pkg::OFF_CMD);
  assign sel_bctl = addr_hit(I_PADDR, pse_pkg::OFF_BCTL);
  assign sel_stat = addr_hit(I_PADDR, pse_pkg::OFF_STAT);
  assign sel_cause = addr_hit(I_PADDR, pse_pkg::OFF_CAUSE);
  assign sel_dis = addr_hit(I_PADDR, pse_pkg::OFF_DIS);
  assign mapped = sel_cmd | sel_bctl | sel_stat | sel_cause | sel_dis;

  // read data prepared in setup so the access phase answers from flops
  assign O_PREADY = 1'b1;
  assign O_PRDATA = rdata_r;
  assign O_PSLVERR = I_PSEL & I_PENABLE & err_r;

  // error decisions
  logic pri_active;
  logic sec_active;
  logic pri_perr_fire;
  logic sec_perr_fire;
  logic pwr_parity;
  logic [pse_pkg::EV_W-1:0] ev_raw;
  logic [pse_pkg::EV_W-1:0] ev_ok;
  logic serr_fire;
  logic sec_serr_seen;

  assign pri_active = I_PRI_CTX.wr_tgt | I_PRI_CTX.rd_init;
  assign sec_active = I_SEC_CTX.wr_tgt | I_SEC_CTX.rd_init;

  assign pri_perr_fire = cmd_r.perr_rsp &
    ((pri_active & I_PRI_CTX.dperr) |
     (I_DS_DWR_CPL & ~I_SEC_PARITY_ERR_N & bctl_r.perr_rsp));

  assign sec_perr_fire = bctl_r.perr_rsp &
    ((sec_active & I_SEC_CTX.dperr) |
     (I_US_DWR_CPL & ~I_PRI_PARITY_ERR_N & cmd_r.perr_rsp));

  assign pwr_parity = cmd_r.perr_rsp & bctl_r.perr_rsp & ~I_PWR_TGT_DET &
    ((I_US_PWR & ~I_PRI_PARITY_ERR_N) | (I_DS_PWR & ~I_SEC_PARITY_ERR_N));

  assign sec_serr_seen = ~I_SEC_SYSTEM_ERR_N;

  always_comb
  begin
    ev_raw = '0;
    ev_raw[pse_pkg::EV_PARITY] = pwr_parity;
    ev_raw[pse_pkg::EV_TABORT] = I_PWR_TABORT;
    ev_raw[pse_pkg::EV_MABORT] = I_PWR_MABORT;
    ev_raw[pse_pkg::EV_PW_RETRY] = I_PWR_RETRY_EXP;
    ev_raw[pse_pkg::EV_DW_RETRY] = I_DWR_RETRY_EXP;
    ev_raw[pse_pkg::EV_DR_RETRY] = I_DRD_RETRY_EXP;
    ev_raw[pse_pkg::EV_MTIMEOUT] = I_MTIMEOUT;
    ev_raw[pse_pkg::EV_SEC_SERR] = sec_serr_seen;
  end

  assign ev_ok = ev_gate(ev_raw, dis_r, bctl_r);
  assign serr_fire = cmd_r.serr_en & (|ev_ok);

  // apb read path
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      rdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end
    else if (setup)
    begin
      err_r <= ~mapped;
      rdata_r <= 32'h0000_0000;
      if (!I_PWRITE)
      begin
        if (sel_cmd)
          rdata_r <= {30'h0000_0000, cmd_r};
        else if (sel_bctl)
          rdata_r <= {29'h0000_0000, bctl_r};
        else if (sel_stat)
          rdata_r <= {30'h0000_0000, stat_r};
        else if (sel_cause)
          rdata_r <= {24'h00_0000, cause_r};
        else if (sel_dis)
          rdata_r <= {24'h00_0000, dis_r};
      end
    end
  end

  // control registers
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      cmd_r <= pse_pkg::CMD_RST;
      bctl_r <= pse_pkg::BCTL_RST;
      dis_r <= pse_pkg::DIS_RST;
    end
    else if (wr_acc)
    begin
      if (sel_cmd)
        cmd_r <= I_PWDATA[1:0];
      if (sel_bctl)
        bctl_r <= I_PWDATA[2:0];
      if (sel_dis)
        dis_r <= I_PWDATA[7:0] & pse_pkg::DIS_MASKABLE;
    end
  end

  // sticky status; a new event in the clearing cycle wins
  logic [1:0] stat_clr;
  logic [1:0] stat_set;
  logic [pse_pkg::EV_W-1:0] cause_clr;

  assign stat_clr = (wr_acc & sel_stat) ? I_PWDATA[1:0] : 2'h0;
  assign cause_clr = (wr_acc & sel_cause) ? I_PWDATA[7:0] : 8'h00;
  assign stat_set = {sec_serr_seen, serr_fire};

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      stat_r <= 2'h0;
    else
      stat_r <= (stat_r & ~stat_clr) | stat_set;
  end

  // cause recorded only for reported events
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      cause_r <= 8'h00;
    else
      cause_r <= (cause_r & ~cause_clr) | (serr_fire ? ev_ok : 8'h00);
  end

  // primary parity pin: low one clock, then driven high before release
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      pri_perr_r <= '0;
    else
    begin
      pri_perr_r.asrt <= pri_perr_fire;
      pri_perr_r.hold <= pri_perr_r.asrt & ~pri_perr_fire;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      sec_perr_r <= '0;
    else
    begin
      sec_perr_r.asrt <= sec_perr_fire;
      sec_perr_r.hold <= sec_perr_r.asrt & ~sec_perr_fire;
    end
  end

  // system error is open drain, one clock low per report
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      pri_serr_r <= 1'b0;
    else
      pri_serr_r <= serr_fire;
  end

  assign O_PRI_PARITY_ERR_N = ~pri_perr_r.asrt;
  assign O_PRI_PARITY_ERR_OE = pri_perr_r.asrt | pri_perr_r.hold;
  assign O_SEC_PARITY_ERR_N = ~sec_perr_r.asrt;
  assign O_SEC_PARITY_ERR_OE = sec_perr_r.asrt | sec_perr_r.hold;
  // pin level low whenever enabled; open drain never drives high
  assign O_PRI_SYSTEM_ERR_N = ~pri_serr_r;
  assign O_PRI_SYSTEM_ERR_OE = pri_serr_r;

  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_N);

  AST_PPERR_ROLE: assert property (
    $rose(O_PRI_PARITY_ERR_OE) |->
      $past(cmd_r.perr_rsp) &&
      ($past(pri_active) || $past(I_DS_DWR_CPL)))
    else $error("primary parity error without role or enable");

  AST_PPERR_DATA: assert property (
    cmd_r.perr_rsp && pri_active && I_PRI_CTX.dperr |=>
      !O_PRI_PARITY_ERR_N ##1 O_PRI_PARITY_ERR_OE)
    else $error("primary data parity error not reported");

  AST_PPERR_DWR: assert property (
    I_DS_DWR_CPL && !I_SEC_PARITY_ERR_N && cmd_r.perr_rsp &&
      bctl_r.perr_rsp |=> !O_PRI_PARITY_ERR_N && O_PRI_PARITY_ERR_OE)
    else $error("downstream delayed write parity not reported");

  AST_PPERR_SECONLY: assert property (
    I_DS_DWR_CPL && !I_SEC_PARITY_ERR_N && !I_PRI_CTX.dperr &&
      cmd_r.perr_rsp && bctl_r.perr_rsp |=> !O_PRI_PARITY_ERR_N)
    else $error("secondary-only fault not reported upstream");

  AST_SPERR_ROLE: assert property (
    !O_SEC_PARITY_ERR_N |->
      $past(sec_active) || $past(I_US_DWR_CPL))
    else $error("secondary parity error without role");

  AST_SPERR_EN: assert property (
    !bctl_r.perr_rsp && !$past(bctl_r.perr_rsp) |=> O_SEC_PARITY_ERR_N)
    else $error("secondary parity error while response disabled");

  AST_SPERR_DATA: assert property (
    bctl_r.perr_rsp && sec_active && I_SEC_CTX.dperr |=>
      !O_SEC_PARITY_ERR_N)
    else $error("secondary data parity error not reported");

  AST_SPERR_DWR: assert property (
    I_US_DWR_CPL && !I_PRI_PARITY_ERR_N && cmd_r.perr_rsp &&
      bctl_r.perr_rsp |=> !O_SEC_PARITY_ERR_N ##1 O_SEC_PARITY_ERR_OE)
    else $error("upstream delayed write parity not reported");

  AST_SERR_PWPAR: assert property (
    I_US_PWR && !I_PRI_PARITY_ERR_N && !I_PWR_TGT_DET &&
      cmd_r.perr_rsp && bctl_r.perr_rsp && cmd_r.serr_en &&
      !dis_r[pse_pkg::EV_PARITY] |=> O_PRI_SYSTEM_ERR_OE)
    else $error("posted write parity system error missing");

  // checked at the pin, with every other event source quiet
  AST_SERR_TGTDET: assert property (
    I_PWR_TGT_DET && (I_US_PWR || I_DS_PWR) &&
      ev_raw[pse_pkg::EV_W-1:1] == 7'h00 |=> !O_PRI_SYSTEM_ERR_OE)
    else $error("posted write parity reported though target detected");

  AST_SERR_BOTHRSP: assert property (
    !(cmd_r.perr_rsp && bctl_r.perr_rsp) && (I_US_PWR || I_DS_PWR) &&
      ev_raw[pse_pkg::EV_W-1:1] == 7'h00 |=> !O_PRI_SYSTEM_ERR_OE)
    else $error("posted write parity without both response bits");

  AST_SERR_EN: assert property (
    O_PRI_SYSTEM_ERR_OE |-> $past(cmd_r.serr_en))
    else $error("system error without enable");

  AST_SERR_SIG: assert property (
    $rose(O_PRI_SYSTEM_ERR_OE) |-> stat_r[pse_pkg::STAT_SIG_BIT])
    else $error("signalled system error bit not set");

  AST_SERR_FWD: assert property (
    sec_serr_seen && bctl_r.fwd_en && cmd_r.serr_en |=>
      !O_PRI_SYSTEM_ERR_N ##1 cause_r[pse_pkg::EV_SEC_SERR])
    else $error("secondary system error not forwarded");

  AST_SERR_RCV: assert property (
    sec_serr_seen |=> stat_r[pse_pkg::STAT_RCV_BIT])
    else $error("received system error bit not set");

  AST_SERR_DIS: assert property (
    I_PWR_TABORT && dis_r[pse_pkg::EV_TABORT] |-> !ev_ok[pse_pkg::EV_TABORT])
    else $error("disabled event not masked");

  AST_SERR_MTO: assert property (
    I_MTIMEOUT && !bctl_r.mto_en |-> !ev_ok[pse_pkg::EV_MTIMEOUT])
    else $error("master timeout reported while its enable clear");

  AST_CAUSE: assert property (
    serr_fire && I_PWR_MABORT && !dis_r[pse_pkg::EV_MABORT] |=>
      cause_r[pse_pkg::EV_MABORT])
    else $error("cause bit not recorded");

  COV_PPERR_DWR: cover property (I_DS_DWR_CPL ##1 !O_PRI_PARITY_ERR_N);
  COV_SPERR: cover property (!O_SEC_PARITY_ERR_N ##1 O_SEC_PARITY_ERR_OE);
  COV_SERR_FWD: cover property (sec_serr_seen ##1 O_PRI_SYSTEM_ERR_OE);
  COV_SERR_RETRY: cover property (I_PWR_RETRY_EXP ##1 O_PRI_SYSTEM_ERR_OE);

endmodule : pse_top

// File: src/pse_pkg.sv
package pse_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_BCTL = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_CAUSE = 8'h0c;
  localparam logic [7:0] OFF_DIS = 8'h10;

  // command register fields
  localparam int CMD_PERR_BIT = 0;
  localparam int CMD_SERR_BIT = 1;
  // bridge control fields
  localparam int BCTL_PERR_BIT = 0;
  localparam int BCTL_FWD_BIT = 1;
  localparam int BCTL_MTO_BIT = 2;
  // status fields, write one to clear
  localparam int STAT_SIG_BIT = 0;
  localparam int STAT_RCV_BIT = 1;

  // event indices in cause and disable registers
  localparam int EV_W = 8;
  localparam int EV_PARITY = 0;
  localparam int EV_TABORT = 1;
  localparam int EV_MABORT = 2;
  localparam int EV_PW_RETRY = 3;
  localparam int EV_DW_RETRY = 4;
  localparam int EV_DR_RETRY = 5;
  localparam int EV_MTIMEOUT = 6;
  localparam int EV_SEC_SERR = 7;
  // events maskable through the disable register
  localparam logic [7:0] DIS_MASKABLE = 8'h3f;

  // reset values
  localparam logic [1:0] CMD_RST = 2'h0;
  localparam logic [2:0] BCTL_RST = 3'h0;
  localparam logic [7:0] DIS_RST = 8'h00;

  typedef struct packed {
    logic serr_en;
    logic perr_rsp;
  } pse_cmd_s;

  typedef struct packed {
    logic mto_en;
    logic fwd_en;
    logic perr_rsp;
  } pse_bctl_s;

  // one bus side's transaction context
  typedef struct packed {
    logic wr_tgt;
    logic rd_init;
    logic dperr;
  } pse_side_s;

  // open-drain / sustained tri-state pin drive
  typedef struct packed {
    logic lvl_n;
    logic oe;
  } pse_pin_s;

endpackage : pse_pkg

// File: sim/pse_bus_agent.sv
`timescale 1ns/1ps
module pse_bus_agent (
  // error requests from the bench
  input wire logic i_pri_perr_req,
  input wire logic i_sec_perr_req,
  input wire logic i_sec_serr_req,
  // bridge pin drive
  input wire logic i_pri_perr_n,
  input wire logic i_pri_perr_oe,
  input wire logic i_sec_perr_n,
  input wire logic i_sec_perr_oe,
  // resolved line levels
  output logic o_pri_perr_n,
  output logic o_sec_perr_n,
  output logic o_sec_serr_n
);
  // pulled-up shared lines: low while any party pulls low
  assign o_pri_perr_n = ~(i_pri_perr_req | (i_pri_perr_oe & ~i_pri_perr_n));
  assign o_sec_perr_n = ~(i_sec_perr_req | (i_sec_perr_oe & ~i_sec_perr_n));
  assign o_sec_serr_n = ~i_sec_serr_req;
endmodule : pse_bus_agent

// File: sim/bridge_parity_system_error_report_bench.sv
`timescale 1ns/1ps
module bridge_parity_system_error_report_bench;
  typedef struct packed {
    logic [1:0] cmd;
    logic [2:0] bc;
    logic [7:0] dis;
    logic [19:0] stim;
    logic [2:0] pin;
    logic [7:0] cause;
    logic [1:0] stat;
  } pse_row_s;
  localparam logic [19:0] PWT = 20'h80000, PRI = 20'h40000, PDP = 20'h20000,
    SWT = 20'h10000, SRI = 20'h08000, SDP = 20'h04000, DSD = 20'h02000,
    USD = 20'h01000, DSP = 20'h00800, USP = 20'h00400, TDT = 20'h00200,
    TAB = 20'h00100, MAB = 20'h00080, PRT = 20'h00040, DRT = 20'h00020,
    RRT = 20'h00010, MTO = 20'h00008, QP = 20'h00004, QS = 20'h00002,
    QE = 20'h00001;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [19:0] stim;
  pse_pkg::pse_side_s pri_ctx, sec_ctx;
  logic ds_dwr, us_dwr, ds_pwr, us_pwr, tgt_det, tab, mab, prt, drt, rrt, mto;
  logic q_pp, q_sp, q_se, pp_in, sp_in, se_in;
  logic pp_n, pp_oe, sp_n, sp_oe, se_n, se_oe;
  logic [2:0] pins;
  int n_mismatch, samples_checked;
  // pin order: primary parity, secondary parity, system error
  pse_row_s rows [26] = '{
    '{2'h1, 3'h0, 8'h00, PWT | PDP, 3'h4, 8'h00, 2'h0},
    '{2'h1, 3'h0, 8'h00, PRI | PDP, 3'h4, 8'h00, 2'h0},
    '{2'h0, 3'h0, 8'h00, PWT | PDP, 3'h0, 8'h00, 2'h0},
    '{2'h1, 3'h0, 8'h00, PDP, 3'h0, 8'h00, 2'h0},
    '{2'h1, 3'h1, 8'h00, DSD | QS, 3'h4, 8'h00, 2'h0},
    '{2'h1, 3'h0, 8'h00, DSD | QS, 3'h0, 8'h00, 2'h0},
    '{2'h0, 3'h1, 8'h00, SRI | SDP, 3'h2, 8'h00, 2'h0},
    '{2'h0, 3'h0, 8'h00, SWT | SDP, 3'h0, 8'h00, 2'h0},
    '{2'h0, 3'h1, 8'h00, SDP, 3'h0, 8'h00, 2'h0},
    '{2'h1, 3'h1, 8'h00, USD | QP, 3'h2, 8'h00, 2'h0},
    '{2'h0, 3'h1, 8'h00, USD | QP, 3'h0, 8'h00, 2'h0},
    '{2'h3, 3'h1, 8'h00, DSP | QS, 3'h1, 8'h01, 2'h1},
    '{2'h3, 3'h1, 8'h00, USP | QP, 3'h1, 8'h01, 2'h1},
    '{2'h3, 3'h1, 8'h00, USP | QP | TDT, 3'h0, 8'h00, 2'h0},
    '{2'h3, 3'h0, 8'h00, DSP | QS, 3'h0, 8'h00, 2'h0},
    '{2'h1, 3'h7, 8'h00, TAB | MTO, 3'h0, 8'h00, 2'h0},
    '{2'h2, 3'h0, 8'h00, TAB, 3'h1, 8'h02, 2'h1},
    '{2'h2, 3'h0, 8'h00, MAB, 3'h1, 8'h04, 2'h1},
    '{2'h2, 3'h0, 8'h00, PRT, 3'h1, 8'h08, 2'h1},
    '{2'h2, 3'h0, 8'h00, DRT, 3'h1, 8'h10, 2'h1},
    '{2'h2, 3'h0, 8'h00, RRT, 3'h1, 8'h20, 2'h1},
    '{2'h2, 3'h4, 8'hff, MTO, 3'h1, 8'h40, 2'h1},
    '{2'h2, 3'h0, 8'h00, MTO, 3'h0, 8'h00, 2'h0},
    '{2'h2, 3'h0, 8'h02, TAB | MAB, 3'h1, 8'h04, 2'h1},
    '{2'h2, 3'h2, 8'h00, QE, 3'h1, 8'h80, 2'h3},
    '{2'h2, 3'h0, 8'h00, QE, 3'h0, 8'h00, 2'h2}
  };
  assign {pri_ctx, sec_ctx, ds_dwr, us_dwr, ds_pwr, us_pwr, tgt_det, tab, mab,
    prt, drt, rrt, mto, q_pp, q_sp, q_se} = stim;
  assign pins = {pp_oe & ~pp_n, sp_oe & ~sp_n, se_oe & ~se_n};
  pse_top #(.ADDR_W(12)) i_pse_top (
    .I_SYS_CLK(sys_clk),
    .I_RST_N(rst_n),
    .I_PSEL(psel),
    .I_PENABLE(penable),
    .I_PWRITE(pwrite),
    .I_PADDR(paddr),
    .I_PWDATA(pwdata),
    .O_PRDATA(prdata),
    .O_PREADY(pready),
    .O_PSLVERR(pslverr),
    .I_PRI_CTX(pri_ctx),
    .I_SEC_CTX(sec_ctx),
    .I_DS_DWR_CPL(ds_dwr),
    .I_US_DWR_CPL(us_dwr),
    .I_DS_PWR(ds_pwr),
    .I_US_PWR(us_pwr),
    .I_PWR_TGT_DET(tgt_det),
    .I_PWR_TABORT(tab),
    .I_PWR_MABORT(mab),
    .I_PWR_RETRY_EXP(prt),
    .I_DWR_RETRY_EXP(drt),
    .I_DRD_RETRY_EXP(rrt),
    .I_MTIMEOUT(mto),
    .I_PRI_PARITY_ERR_N(pp_in),
    .I_SEC_PARITY_ERR_N(sp_in),
    .I_SEC_SYSTEM_ERR_N(se_in),
    .O_PRI_PARITY_ERR_N(pp_n),
    .O_PRI_PARITY_ERR_OE(pp_oe),
    .O_SEC_PARITY_ERR_N(sp_n),
    .O_SEC_PARITY_ERR_OE(sp_oe),
    .O_PRI_SYSTEM_ERR_N(se_n),
    .O_PRI_SYSTEM_ERR_OE(se_oe)
  );
  pse_bus_agent i_pse_bus_agent (
    .i_pri_perr_req(q_pp),
    .i_sec_perr_req(q_sp),
    .i_sec_serr_req(q_se),
    .i_pri_perr_n(pp_n),
    .i_pri_perr_oe(pp_oe),
    .i_sec_perr_n(sp_n),
    .i_sec_perr_oe(sp_oe),
    .o_pri_perr_n(pp_in),
    .o_sec_perr_n(sp_in),
    .o_sec_serr_n(se_in)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // master holds the request until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {4'h0, a};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask : rdc
  // one-cycle cause, outputs looked at just after the answering edge
  task automatic fire(input logic [19:0] s);
    @(posedge sys_clk);
    stim <= s;
    @(posedge sys_clk);
    stim <= '0;
    #1;
  endtask : fire
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // whole run needs about 670 cycles
  initial
  begin
    repeat (6000) @(posedge sys_clk);
    n_mismatch++;
    wrap_up();
  end
  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    stim = '0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (5) @(posedge sys_clk);
    #1;
    chk({29'h0, pp_oe, sp_oe, se_oe}, 32'h0);
    chk({29'h0, pp_n, sp_n, se_n}, 32'h7);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      rdc(8'(4 * i), 32'h0);
    end
    apb(1'b1, pse_pkg::OFF_CMD, 32'hffffffff);
    rdc(pse_pkg::OFF_CMD, 32'h3);
    apb(1'b1, pse_pkg::OFF_BCTL, 32'hffffffff);
    rdc(pse_pkg::OFF_BCTL, 32'h7);
    apb(1'b1, pse_pkg::OFF_DIS, 32'hffffffff);
    rdc(pse_pkg::OFF_DIS, 32'h3f);
    apb(1'b1, 8'h14, 32'hffffffff);
    rdc(8'h14, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    $display("register test done");
    foreach (rows[i])
    begin
      apb(1'b1, pse_pkg::OFF_CMD, {30'h0, rows[i].cmd});
      apb(1'b1, pse_pkg::OFF_BCTL, {29'h0, rows[i].bc});
      apb(1'b1, pse_pkg::OFF_DIS, {24'h0, rows[i].dis});
      apb(1'b1, pse_pkg::OFF_STAT, 32'h3);
      apb(1'b1, pse_pkg::OFF_CAUSE, 32'hff);
      fire(rows[i].stim);
      chk({29'h0, pins}, {29'h0, rows[i].pin});
      rdc(pse_pkg::OFF_STAT, {30'h0, rows[i].stat});
      rdc(pse_pkg::OFF_CAUSE, {24'h0, rows[i].cause});
      $display("row %0d done", i);
    end
    apb(1'b1, pse_pkg::OFF_CMD, 32'h3);
    apb(1'b1, pse_pkg::OFF_DIS, 32'h0);
    fire(PWT | PDP | TAB);
    chk({28'h0, pp_n, pp_oe, se_n, se_oe}, 32'h5);
    @(posedge sys_clk);
    #1;
    chk({28'h0, pp_n, pp_oe, se_n, se_oe}, 32'he);
    @(posedge sys_clk);
    #1;
    chk({28'h0, pp_n, pp_oe, se_n, se_oe}, 32'ha);
    $display("pin timing test done");
    @(posedge sys_clk);
    stim <= TAB;
    @(posedge sys_clk);
    @(posedge sys_clk);
    stim <= '0;
    #1;
    chk({31'h0, se_n}, 32'h0);
    @(posedge sys_clk);
    #1;
    chk({31'h0, se_n}, 32'h1);
    $display("back-to-back test done");
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk({29'h0, pp_oe, sp_oe, se_oe}, 32'h0);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    rdc(pse_pkg::OFF_CMD, 32'h0);
    rdc(pse_pkg::OFF_STAT, 32'h0);
    $display("second reset test done");
    wrap_up();
  end
endmodule : bridge_parity_system_error_report_bench
